// ### logic/output_mute_control.sv
// Register bank and auto-mute logic for the clock outputs
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Differential muted state: 0 bypass, 1 common mode, 2 high, 3 rail split.
// - CMOS muted state: 0 bypass, 1 N low, 2 P low, 3 both low.
// - Level only shapes a muted channel; enable bit and reference validity decide muting.
// - Enabled channel mutes while selected reference is invalid; enables reset 1.
// - Channel with enable cleared keeps running regardless of reference.
// - Clocking status pin mutes on invalid reference; resets B 1, A 0.
// - Status pin not carrying a clock never mutes.
// - Margin delay enable acts only for divide values above 8; resets 0.
// - Bits 5 to 2 serve channels 7 to 4; bits 1, 0 pairs.
// - Detector bypass treats both references valid, so nothing mutes.
module output_mute_control (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_r,
  // Reference status
  input wire logic pri_valid_async,
  input wire logic sec_valid_async,
  input wire logic use_secondary,
  // Output driver configuration
  input wire logic [3:0] ch_cmos_mode,
  input wire logic [7:0][7:0] div_ratio,
  input wire logic indicator_a_is_clock,
  input wire logic indicator_b_is_clock,
  // Output driver control
  output logic [7:0] ch_disable_r,
  output logic [3:0][1:0] ch_diff_drive_r,
  output logic [3:0] ch_pos_low_r,
  output logic [3:0] ch_neg_low_r,
  output logic indicator_a_disable_r,
  output logic indicator_b_disable_r,
  output logic [7:0] margin_active_r
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] level_r;
  logic [7:0] auto_en_r;
  logic [1:0] stat_mute_r;
  logic [5:0] margin_r;
  logic bypass_r;
  logic [1:0] valid_sync;
  logic src_valid;
  logic [7:0] mute_nxt;
  logic ind_a_nxt;
  logic ind_b_nxt;
  logic [7:0] margin_map;
  logic [7:0] rdata_nxt;

  mute_cfg_if cfg ();

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Spread the six enables over the eight dividers
  function automatic logic [7:0] margin_spread(input logic [5:0] r);
    margin_spread = {r[5:2],
                     r[mute_pkg::MARGIN_PAIR23_BIT],
                     r[mute_pkg::MARGIN_PAIR23_BIT],
                     r[mute_pkg::MARGIN_PAIR01_BIT],
                     r[mute_pkg::MARGIN_PAIR01_BIT]};
  endfunction : margin_spread

  function automatic logic wr_hit(input logic [7:0] ofs,
                                  input logic wr,
                                  input logic [7:0] addr);
    wr_hit = wr && (addr == ofs);
  endfunction : wr_hit

  ////////////////////////////////////////////////////////////////////////
  // Registers

  // Muted drive levels, channels 4 to 7
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_r <= mute_pkg::RST_MUTE_LEVEL;
    end else if (wr_hit(mute_pkg::OFS_MUTE_LEVEL, reg_wr, reg_addr)) begin
      level_r <= reg_wdata;
    end
  end

  // Channel auto-mute enables
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      auto_en_r <= mute_pkg::RST_AUTO_MUTE;
    end else if (wr_hit(mute_pkg::OFS_AUTO_MUTE, reg_wr, reg_addr)) begin
      auto_en_r <= reg_wdata;
    end
  end

  // Status pin auto-mute enables
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stat_mute_r <= mute_pkg::RST_STATUS_MUTE;
    end else if (wr_hit(mute_pkg::OFS_STATUS_MUTE, reg_wr, reg_addr)) begin
      stat_mute_r <= reg_wdata[mute_pkg::STATUS_MUTE_W-1:0];
    end
  end

  // Divider margin delay enables
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      margin_r <= mute_pkg::RST_MARGIN;
    end else if (wr_hit(mute_pkg::OFS_MARGIN, reg_wr, reg_addr)) begin
      margin_r <= reg_wdata[mute_pkg::MARGIN_W-1:0];
    end
  end

  // Detector bypass
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bypass_r <= mute_pkg::RST_DETECT_BYPASS;
    end else if (wr_hit(mute_pkg::OFS_DETECT_CTL, reg_wr, reg_addr)) begin
      bypass_r <= reg_wdata[mute_pkg::BYPASS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      mute_pkg::OFS_MUTE_LEVEL: rdata_nxt = level_r;
      mute_pkg::OFS_AUTO_MUTE: rdata_nxt = auto_en_r;
      mute_pkg::OFS_STATUS_MUTE: rdata_nxt = {6'h00, stat_mute_r};
      mute_pkg::OFS_MARGIN: rdata_nxt = {2'h0, margin_r};
      mute_pkg::OFS_DETECT_CTL: rdata_nxt = {7'h00, bypass_r};
      mute_pkg::OFS_BLOCK_STATE: begin
        rdata_nxt[mute_pkg::STATE_VALID_BIT] = src_valid;
        rdata_nxt[mute_pkg::STATE_IND_A_BIT] = indicator_a_disable_r;
        rdata_nxt[mute_pkg::STATE_IND_B_BIT] = indicator_b_disable_r;
      end
      default: rdata_nxt = 8'h00;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_r <= rdata_nxt;
    end else begin
      reg_rdata_r <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reference validity

  valid_sync u_valid_sync (
    .sys_clk (sys_clk),
    .rst_b (rst_b),
    .async_in ({sec_valid_async, pri_valid_async}),
    .sync_out (valid_sync)
  );

  // Bypass forces both references valid
  assign src_valid = bypass_r ||
                     (use_secondary ? valid_sync[1] : valid_sync[0]);

  ////////////////////////////////////////////////////////////////////////
  // Mute requests

  assign mute_nxt = auto_en_r & {8{!src_valid}};
  assign ind_a_nxt = indicator_a_is_clock &&
                     stat_mute_r[mute_pkg::IND_A_BIT] && !src_valid;
  assign ind_b_nxt = indicator_b_is_clock &&
                     stat_mute_r[mute_pkg::IND_B_BIT] && !src_valid;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ch_disable_r <= 8'h00;
    end else begin
      ch_disable_r <= mute_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      indicator_a_disable_r <= 1'b0;
      indicator_b_disable_r <= 1'b0;
    end else begin
      indicator_a_disable_r <= ind_a_nxt;
      indicator_b_disable_r <= ind_b_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Muted drive shaping

  assign cfg.level = level_r;
  assign cfg.mute_req = mute_nxt[7:4];
  assign cfg.cmos_mode = ch_cmos_mode;

  drive_shaper u_drive_shaper (
    .cfg (cfg.shaper)
  );

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ch_diff_drive_r <= '0;
      ch_pos_low_r <= 4'h0;
      ch_neg_low_r <= 4'h0;
    end else begin
      ch_diff_drive_r <= cfg.diff_drive;
      ch_pos_low_r <= cfg.pos_low;
      ch_neg_low_r <= cfg.neg_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider margining

  assign margin_map = margin_spread(margin_r);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      margin_active_r <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        margin_active_r[i] <= margin_map[i] &&
                              (div_ratio[i] > mute_pkg::MARGIN_MIN_DIV);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (!rst_b);

  // Primary selected, bypass clear and lost for three edges
  sequence pri_lost_s;
    (!pri_valid_async && !use_secondary && !bypass_r) [*3];
  endsequence

  sequence sec_lost_s;
    (!sec_valid_async && use_secondary && !bypass_r) [*3];
  endsequence

  sequence all_enabled_s;
    auto_en_r == 8'hFF;
  endsequence

  property loss_mutes_p;
    (pri_lost_s ##0 all_enabled_s) or (sec_lost_s ##0 all_enabled_s)
      |=> (ch_disable_r == 8'hFF);
  endproperty

  AST_LOSS_MUTES_ALL: assert property (loss_mutes_p)
    else $error("enabled channels not muted after reference loss");

  AST_DISABLED_RUNS: assert property (
    (auto_en_r == 8'h00) |=> (ch_disable_r == 8'h00))
    else $error("channel muted with its enable cleared");

  AST_BYPASS_NO_MUTE: assert property (
    bypass_r |=> (ch_disable_r == 8'h00) && !indicator_a_disable_r
      && !indicator_b_disable_r)
    else $error("mute raised while detector bypass is set");

  AST_IND_NOT_CLOCK: assert property (
    !indicator_a_is_clock && !indicator_b_is_clock
      |=> !indicator_a_disable_r && !indicator_b_disable_r)
    else $error("status pin muted while not carrying a clock");

  AST_IND_B_MUTE: assert property (
    pri_lost_s ##0 (indicator_b_is_clock && stat_mute_r[1])
      |=> indicator_b_disable_r)
    else $error("clocking status pin not muted on loss");

  AST_LEVEL_ONLY_MUTED: assert property (
    !ch_disable_r[4] |-> (ch_diff_drive_r[0] == 2'h0)
      && !ch_pos_low_r[0] && !ch_neg_low_r[0])
    else $error("drive shaped on an unmuted channel");

  AST_DIFF_HIGH: assert property (
    ch_disable_r[4] && !$past(ch_cmos_mode[0])
      && ($past(level_r[1:0]) == 2'h2)
      |-> (ch_diff_drive_r[0] == 2'h2) && !ch_pos_low_r[0])
    else $error("differential force-high level not applied");

  AST_CMOS_BOTH_LOW: assert property (
    ch_disable_r[5] && $past(ch_cmos_mode[1])
      && ($past(level_r[3:2]) == 2'h3)
      |-> ch_pos_low_r[1] && ch_neg_low_r[1]
      && (ch_diff_drive_r[1] == 2'h0))
    else $error("CMOS both-low level not applied");

  AST_MARGIN_LIMIT: assert property (
    margin_active_r[0] |-> ($past(div_ratio[0]) > 8'h08)
      && $past(margin_r[0]))
    else $error("margining active at divide value of 8 or less");

  AST_PAIR_SHARED: assert property (
    $past(margin_r[1]) && ($past(div_ratio[2]) > 8'h08)
      && ($past(div_ratio[3]) > 8'h08)
      |-> margin_active_r[2] && margin_active_r[3])
    else $error("shared pair enable not applied to both dividers");

  AST_IND_A_MUTE: assert property (
    sec_lost_s ##0 (indicator_a_is_clock && stat_mute_r[0])
      |=> indicator_a_disable_r)
    else $error("clocking status pin A not muted on loss");

  AST_CH3_ENABLE_GATES: assert property (
    !auto_en_r[3] |=> !ch_disable_r[3])
    else $error("channel 3 muted with its enable cleared");

  AST_CH7_LEVEL_ONLY_MUTED: assert property (
    !ch_disable_r[7] |-> (ch_diff_drive_r[3] == 2'h0)
      && !ch_pos_low_r[3] && !ch_neg_low_r[3])
    else $error("drive shaped on unmuted channel 7");

  AST_DIFF_COMMON_MODE: assert property (
    ch_disable_r[6] && !$past(ch_cmos_mode[2])
      && ($past(level_r[5:4]) == 2'h1)
      |-> (ch_diff_drive_r[2] == 2'h1) && !ch_neg_low_r[2])
    else $error("differential common-mode level not applied");

  AST_READ_ONE_CYCLE: assert property (
    !$past(reg_rd) |-> (reg_rdata_r == 8'h00))
    else $error("read data outside the answer cycle");

endmodule : output_mute_control
`default_nettype wire

// ### pkg/mute_pkg.sv
// Constants and helpers shared by the output mute control block
package mute_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int LVL_W = 2;
  // Register offsets
  localparam logic [7:0] OFS_MUTE_LEVEL = 8'h15;
  localparam logic [7:0] OFS_AUTO_MUTE = 8'h16;
  localparam logic [7:0] OFS_STATUS_MUTE = 8'h17;
  localparam logic [7:0] OFS_MARGIN = 8'h18;
  localparam logic [7:0] OFS_DETECT_CTL = 8'h19;
  localparam logic [7:0] OFS_BLOCK_STATE = 8'h1A;
  // Reset values
  localparam logic [7:0] RST_MUTE_LEVEL = 8'h55;
  localparam logic [7:0] RST_AUTO_MUTE = 8'hFF;
  localparam logic [1:0] RST_STATUS_MUTE = 2'h2;
  localparam logic [5:0] RST_MARGIN = 6'h00;
  localparam logic RST_DETECT_BYPASS = 1'b0;
  // Field positions
  localparam int STATUS_MUTE_W = 2;
  localparam int MARGIN_W = 6;
  localparam int IND_A_BIT = 0;
  localparam int IND_B_BIT = 1;
  localparam int MARGIN_PAIR01_BIT = 0;
  localparam int MARGIN_PAIR23_BIT = 1;
  localparam int MARGIN_CH4_BIT = 2;
  localparam int BYPASS_BIT = 0;
  localparam int STATE_VALID_BIT = 0;
  localparam int STATE_IND_A_BIT = 1;
  localparam int STATE_IND_B_BIT = 2;
  // Margining needs a divide value above this
  localparam logic [7:0] MARGIN_MIN_DIV = 8'h08;

  typedef enum logic [1:0] {
    LVL_BYPASS,
    LVL_COMMON_MODE,
    LVL_FORCE_HIGH,
    LVL_RAIL_SPLIT
  } mute_level_type;

  // Muted drive level of one upper channel, index 0 to 3
  function automatic mute_level_type lvl_field(input logic [7:0] r,
                                               input int idx);
    lvl_field = mute_level_type'(r[idx*LVL_W +: LVL_W]);
  endfunction : lvl_field
endpackage : mute_pkg

// ### pkg/mute_cfg_if.sv
// Mute request and drive shaping signals between control and shaper
`timescale 1ns/1ps
`default_nettype none
interface mute_cfg_if;
  logic [7:0] level;
  logic [3:0] mute_req;
  logic [3:0] cmos_mode;
  logic [3:0][1:0] diff_drive;
  logic [3:0] pos_low;
  logic [3:0] neg_low;
  modport ctrl (output level, output mute_req, output cmos_mode,
                input diff_drive, input pos_low, input neg_low);
  modport shaper (input level, input mute_req, input cmos_mode,
                  output diff_drive, output pos_low, output neg_low);
endinterface : mute_cfg_if
`default_nettype wire

// ### logic/valid_sync.sv
// Two-stage synchroniser for the reference valid levels
`timescale 1ns/1ps
`default_nettype none
module valid_sync (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Levels
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] stage1_r;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_r <= 2'h0;
      sync_out <= 2'h0;
    end else begin
      stage1_r <= async_in;
      sync_out <= stage1_r;
    end
  end
endmodule : valid_sync
`default_nettype wire

// ### logic/drive_shaper.sv
// Muted drive state decode for channels 4 to 7
`timescale 1ns/1ps
`default_nettype none
module drive_shaper (
  // Configuration and requests
  mute_cfg_if.shaper cfg
);
  always_comb begin
    mute_pkg::mute_level_type lvl;
    lvl = mute_pkg::LVL_BYPASS;
    for (int i = 0; i < 4; i++) begin
      lvl = mute_pkg::lvl_field(cfg.level, i);
      cfg.diff_drive[i] = 2'h0;
      cfg.pos_low[i] = 1'b0;
      cfg.neg_low[i] = 1'b0;
      // Level only shapes a channel that is muted
      if (cfg.mute_req[i]) begin
        if (cfg.cmos_mode[i]) begin
          unique case (lvl)
            mute_pkg::LVL_BYPASS: cfg.pos_low[i] = 1'b0;
            mute_pkg::LVL_COMMON_MODE: cfg.neg_low[i] = 1'b1;
            mute_pkg::LVL_FORCE_HIGH: cfg.pos_low[i] = 1'b1;
            mute_pkg::LVL_RAIL_SPLIT: begin
              cfg.pos_low[i] = 1'b1;
              cfg.neg_low[i] = 1'b1;
            end
          endcase
        end else begin
          cfg.diff_drive[i] = lvl;
        end
      end
    end
  end
endmodule : drive_shaper
`default_nettype wire

// ### dv/clock_load_model.sv
// Downstream clock loads fed by the output drivers
`timescale 1ns/1ps
`default_nettype none
module clock_load_model (
  // Clock
  input wire logic sys_clk,
  // Driver control
  input wire logic [7:0] ch_disable_r,
  input wire logic [3:0] ch_pos_low_r,
  input wire logic [3:0] ch_neg_low_r,
  input wire logic indicator_a_disable_r,
  input wire logic indicator_b_disable_r,
  // Load view
  output logic [9:0] load_running,
  output logic [3:0] pos_leg,
  output logic [3:0] neg_leg
);
  // Load sees a clock only while its driver is live
  assign load_running = {~indicator_b_disable_r, ~indicator_a_disable_r,
                         ~ch_disable_r};
  // Forced legs sit at ground, others toggle
  assign pos_leg = ~ch_pos_low_r & {4{sys_clk}};
  assign neg_leg = ~ch_neg_low_r & {4{~sys_clk}};
endmodule : clock_load_model
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the output mute control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int TIMEOUT = 4000;
  localparam logic [7:0] MASK [0:4] = '{8'hFF, 8'hFF, 8'h03, 8'h3F, 8'h01};
  logic sys_clk, rst_b, reg_wr, reg_rd, rd_d, snap;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_r, ch_disable_r, margin_active_r;
  logic pri_valid_async, sec_valid_async, use_secondary;
  logic [3:0] ch_cmos_mode, ch_pos_low_r, ch_neg_low_r;
  logic [7:0][7:0] div_ratio;
  logic [3:0][1:0] ch_diff_drive_r;
  logic indicator_a_is_clock, indicator_b_is_clock;
  logic indicator_a_disable_r, indicator_b_disable_r;
  logic [7:0] mir [0:4];
  logic [33:0] exp_q [$];
  logic [31:0] seed, r, r2;
  int miscompares, total_checks, cycles;

  output_mute_control u_output_mute_control (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_r(reg_rdata_r), .pri_valid_async(pri_valid_async),
    .sec_valid_async(sec_valid_async), .use_secondary(use_secondary),
    .ch_cmos_mode(ch_cmos_mode), .div_ratio(div_ratio),
    .indicator_a_is_clock(indicator_a_is_clock),
    .indicator_b_is_clock(indicator_b_is_clock),
    .ch_disable_r(ch_disable_r), .ch_diff_drive_r(ch_diff_drive_r),
    .ch_pos_low_r(ch_pos_low_r), .ch_neg_low_r(ch_neg_low_r),
    .indicator_a_disable_r(indicator_a_disable_r),
    .indicator_b_disable_r(indicator_b_disable_r),
    .margin_active_r(margin_active_r));

  clock_load_model u_clock_load_model (
    .sys_clk(sys_clk), .ch_disable_r(ch_disable_r),
    .ch_pos_low_r(ch_pos_low_r), .ch_neg_low_r(ch_neg_low_r),
    .indicator_a_disable_r(indicator_a_disable_r),
    .indicator_b_disable_r(indicator_b_disable_r),
    .load_running(), .pos_leg(), .neg_leg());

  always #12.5 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Expected driver outputs from mirror and inputs
  function automatic logic [33:0] exp_out();
    logic valid;
    logic [7:0] mute, diff, marg, en;
    logic [3:0] pl, nl;
    logic [1:0] lv;
    logic ia, ib;
    valid = mir[4][0] | (use_secondary ? sec_valid_async : pri_valid_async);
    mute = mir[1] & {8{~valid}};
    for (int i = 0; i < 4; i++) begin
      lv = mir[0][2*i +: 2];
      diff[2*i +: 2] = (mute[4+i] && !ch_cmos_mode[i]) ? lv : 2'h0;
      pl[i] = mute[4+i] & ch_cmos_mode[i] & lv[1];
      nl[i] = mute[4+i] & ch_cmos_mode[i] & lv[0];
    end
    ia = indicator_a_is_clock & mir[2][0] & ~valid;
    ib = indicator_b_is_clock & mir[2][1] & ~valid;
    en = {mir[3][5:2], {2{mir[3][1]}}, {2{mir[3][0]}}};
    for (int i = 0; i < 8; i++) begin
      marg[i] = en[i] & (div_ratio[i] > 8'h08);
    end
    return {mute, diff, pl, nl, ib, ia, marg};
  endfunction : exp_out

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h15 && a <= 8'h19) begin
      mir[a-8'h15] = d & MASK[a-8'h15];
    end
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a);
    logic [7:0] e;
    logic [33:0] o;
    o = exp_out();
    e = (a >= 8'h15 && a <= 8'h19) ? mir[a-8'h15] : 8'h00;
    if (a == 8'h1A) begin
      e = {5'h00, o[9:8], mir[4][0] | (use_secondary ? sec_valid_async :
                                       pri_valid_async)};
    end
    exp_q.push_back({26'h0, e});
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : reg_read

  task automatic expect_out();
    exp_q.push_back(exp_out());
    snap <= 1'b1;
    @(posedge sys_clk);
    snap <= 1'b0;
    @(posedge sys_clk);
  endtask : expect_out

  task automatic compare(input string what, input logic [33:0] seen);
    logic [33:0] e;
    e = exp_q.size() > 0 ? exp_q.pop_front() : 34'h0;
    total_checks++;
    if (seen !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, e, seen);
    end
  endtask : compare

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  ////////////////////////////////////////////////////////////////////////
  // Result watcher
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'b1) begin
      compare("reg_rdata_r", {26'h0, reg_rdata_r});
    end
    if (snap === 1'b1) begin
      compare("outputs", {ch_disable_r, ch_diff_drive_r, ch_pos_low_r,
                          ch_neg_low_r, indicator_b_disable_r,
                          indicator_a_disable_r, margin_active_r});
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      miscompares++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    rst_b = 1'b0;
    {reg_wr, reg_rd, snap} = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {pri_valid_async, sec_valid_async, use_secondary} = 3'b110;
    ch_cmos_mode = 4'h0;
    div_ratio = '0;
    {indicator_a_is_clock, indicator_b_is_clock} = 2'b11;
    mir = '{8'h55, 8'hFF, 8'h02, 8'h00, 8'h00};
    seed = 32'hA740;
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int a = 0; a < 5; a++) begin
      reg_read(8'h15 + a[7:0]);
    end
    reg_read(8'h20);
    expect_out();
    $display("Test reset values done");
    for (int a = 0; a < 5; a++) begin
      r = rnd();
      reg_write(8'h15 + a[7:0], r[7:0]);
    end
    reg_write(8'h30, 8'hA5);
    reg_write(8'h1A, 8'hFF);
    reg_read(8'h30);
    for (int a = 0; a < 5; a++) begin
      reg_read(8'h15 + a[7:0]);
    end
    $display("Test register access done");
    reg_write(8'h15, 8'hFF);
    reg_write(8'h15, 8'h1E);
    reg_write(8'h16, 8'hFF);
    reg_write(8'h17, 8'h03);
    reg_write(8'h19, 8'h00);
    ch_cmos_mode <= 4'h2;
    {indicator_a_is_clock, indicator_b_is_clock} <= 2'b11;
    {pri_valid_async, sec_valid_async, use_secondary} <= 3'b010;
    repeat (4) @(posedge sys_clk);
    expect_out();
    reg_read(8'h1A);
    {pri_valid_async, sec_valid_async, use_secondary} <= 3'b101;
    repeat (4) @(posedge sys_clk);
    expect_out();
    reg_write(8'h16, 8'h00);
    reg_write(8'h17, 8'h00);
    expect_out();
    reg_write(8'h16, 8'hF0);
    reg_write(8'h19, 8'h01);
    expect_out();
    reg_read(8'h1A);
    $display("Test directed mute done");
    for (int n = 0; n < 60; n++) begin
      r = rnd();
      reg_write(8'h15, r[7:0]);
      reg_write(8'h16, r[15:8]);
      reg_write(8'h17, {6'h0, r[17:16]});
      reg_write(8'h18, {2'h0, r[29:24]});
      reg_write(8'h19, {7'h0, r[31] & r[30]});
      r = rnd();
      pri_valid_async <= r[0];
      sec_valid_async <= r[1];
      use_secondary <= r[2];
      ch_cmos_mode <= r[6:3];
      indicator_a_is_clock <= r[7];
      indicator_b_is_clock <= r[8];
      for (int i = 0; i < 8; i++) begin
        r2 = rnd();
        div_ratio[i] <= 8'h06 + r2[7:0] % 8'h05;
      end
      repeat (4) @(posedge sys_clk);
      expect_out();
    end
    $display("Test random mute traffic done");
    print_verdict();
  end
endmodule : tb
`default_nettype wire
